// [gpm_bank.v]
// Purpose : One bidirectional GPIO bank: direction and output storage
// Assumes : Write strobes come from the parent decoder on CLK_SYS
// Notes   : Only the low W bits exist; higher bits read zero
`timescale 1ns/1ps
`include "gpm_regs.vh"
module gpm_bank #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         clk,
    input  wire         srst,
    // Register writes
    input  wire         wr_dir,
    input  wire         wr_out,
    input  wire [7:0]   wdata,
    // Stored state
    output reg  [W-1:0] dir,
    output reg  [W-1:0] out_val
);
    // Reset patterns at full byte width, cut to the bank width below
    wire [7:0] rst_dir = `GPM_RST_DIR;  // Direction reset pattern
    wire [7:0] rst_out = `GPM_RST_OUT;  // Output reset pattern
    // =============================================
    // Direction and output registers
    always @(posedge clk) begin
        if (srst) begin
            dir     <= rst_dir[W-1:0];
            out_val <= rst_out[W-1:0];
        end else begin
            if (wr_dir) begin
                dir <= wdata[W-1:0];
            end
            if (wr_out) begin
                out_val <= wdata[W-1:0];
            end
        end
    end
endmodule

// [gpm_board.sv]
// Purpose: Board side of the shared GPIO pads
// Assumes: An undriven pad takes the board level
// Notes: A driven pad reads back its own drive
`timescale 1ns/1ps
// ==========================
// Pad resolution
module gpm_board (
    // Pad drive from the block
    input  logic [21:0] pad_o,
    input  logic [21:0] pad_oe,
    // Board level on each pad
    input  logic [21:0] ext,
    // Level seen by the block
    output logic [21:0] pad_i
);
    // Block drive wins; the board level shows only when released
    assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext);
endmodule

// [gpm_props.sv]
// Purpose: Port checks for the GPIO and pin select block
// Assumes: One clock, synchronous reset
// Notes: Bound to every gpm_top
`timescale 1ns/1ps
// ==========================
// Checker
module gpm_props (
    // Clock, reset and bus
    input logic        CLK_SYS,
    input logic        SRST,
    input logic [15:0] ADDR,
    input logic        WR,
    input logic        RD,
    input logic [7:0]  WDATA,
    input logic [7:0]  RDATA,
    // Pins and selects
    input logic [21:0] GPIO_O,
    input logic [21:0] GPIO_OE,
    input logic [11:0] OUT_PIN,
    input logic [4:0]  IRQ_SRC,
    input logic        SYSTEM_MGMT_INTERRUPT_N,
    input logic        KBD_PORT_CLOCK_I,
    input logic        KBD_PORT_DATA_I,
    input logic [3:0]  KBD_CHANNEL_EN,
    input logic [3:0]  KBD_CHANNEL_CLK_I,
    input logic [3:0]  KBD_CHANNEL_DAT_I,
    input logic        IR_BLOCK_TX,
    input logic        IR_DATA_TX,
    input logic        INFRARED_TX_PIN,
    input logic        IR_UART_TX,
    input logic [7:0]  FSEL
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    // Write and read steps
    sequence s_wr(a);
        WR && ADDR == a;
    endsequence
    sequence s_rd(a);
        RD && !WR && ADDR == a;
    endsequence
    AST_RESET_STATE:
    assert property ($fell(SRST) |-> GPIO_OE == 22'h0 && OUT_PIN == 12'hfff && FSEL == 8'h00)
        else $error("reset state wrong");
    AST_DIR_A:
    assert property (s_wr(16'h7f18) |=> GPIO_OE[7:0] == $past(WDATA))
        else $error("direction write not on pins");
    AST_OUT_A:
    assert property (s_wr(16'h7f19) |=> ((GPIO_O[7:0] ^ $past(WDATA)) & GPIO_OE[7:0]) == 8'h00)
        else $error("output write not on pins");
    AST_FSEL_RD:
    assert property (s_rd(16'h7f3d) |=> RDATA == $past(FSEL))
        else $error("select readback wrong");
    AST_UNMAPPED:
    assert property (s_rd(16'h7f21) |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    AST_BANK_C_TOP:
    assert property (RD && ADDR inside {16'h7f1e, 16'h7f1f, 16'h7f20} |=> RDATA[7:6] == 2'b00)
        else $error("bank C top bits set");
    AST_PS2_OFF:
    assert property (!FSEL[1] [*4] |-> KBD_PORT_CLOCK_I && KBD_PORT_DATA_I)
        else $error("port inputs not high");
    AST_CHAN_PULL:
    assert property ((~KBD_CHANNEL_EN & ~(KBD_CHANNEL_CLK_I & KBD_CHANNEL_DAT_I)) == 4'h0)
        else $error("idle channel not high");
    AST_IR_TX:
    assert property (!$past(SRST) && $stable(FSEL) && $stable(IR_DATA_TX) && $stable(IR_BLOCK_TX)
                     |-> INFRARED_TX_PIN == (FSEL[2] ? IR_DATA_TX : IR_BLOCK_TX))
        else $error("infrared source wrong");
    AST_IRQ_ROUTE:
    assert property (FSEL[0] |-> OUT_PIN[4:0] == IRQ_SRC && OUT_PIN[7] == SYSTEM_MGMT_INTERRUPT_N)
        else $error("interrupt route wrong");
    AST_IR_UART:
    assert property (FSEL[7] |-> !GPIO_OE[8] && GPIO_O[9] == IR_UART_TX)
        else $error("infrared uart pins wrong");
endmodule
bind gpm_top gpm_props gpm_props_inst (.CLK_SYS, .SRST, .ADDR, .WR, .RD, .WDATA, .RDATA, .GPIO_O, .GPIO_OE,
    .OUT_PIN, .IRQ_SRC, .SYSTEM_MGMT_INTERRUPT_N, .KBD_PORT_CLOCK_I, .KBD_PORT_DATA_I, .KBD_CHANNEL_EN,
    .KBD_CHANNEL_CLK_I, .KBD_CHANNEL_DAT_I, .IR_BLOCK_TX, .IR_DATA_TX, .INFRARED_TX_PIN, .IR_UART_TX, .FSEL);

// [gpm_regs.vh]
// Purpose : Offsets, field positions and reset values for the GPIO/pin-mux block
// Assumes : Controller data space addressed with 16-bit addresses
// Notes   : Definitions only
`ifndef GPM_REGS_VH
`define GPM_REGS_VH
// =============================================
// Register offsets
`define GPM_DIR_A      16'h7f18
`define GPM_OUT_A      16'h7f19
`define GPM_IN_A       16'h7f1a
`define GPM_DIR_B      16'h7f1b
`define GPM_OUT_B      16'h7f1c
`define GPM_IN_B       16'h7f1d
`define GPM_DIR_C      16'h7f1e
`define GPM_OUT_C      16'h7f1f
`define GPM_IN_C       16'h7f20
`define GPM_OUTONLY_LO 16'h7f22
`define GPM_OUTONLY_HI 16'h7f23
`define GPM_INONLY     16'h7f24
`define GPM_FSEL1      16'h7f3d
// =============================================
// Reset values
`define GPM_RST_DIR    8'h00
`define GPM_RST_OUT    8'h00
`define GPM_RST_OLO    8'hff
`define GPM_RST_OHI    8'h0f
`define GPM_RST_FSEL   8'h00
// =============================================
// Field positions in the function select register
`define GPM_IRQ_ROUTE  0
`define GPM_PS2_SEL    1
`define GPM_IR_SRC     2
`define GPM_UTX_SEL    3
`define GPM_PWM_SEL    4
`define GPM_FLOPPY_SEL 5
`define GPM_A20_SEL    6
`define GPM_IRUART_SEL 7
// Implemented widths of banks
`define GPM_C_BITS     6
`define GPM_OHI_BITS   4
`endif

// [gpm_sync.v]
// Purpose : Three-stage synchroniser for a bus of pin inputs
// Assumes : Inputs asynchronous to CLK_SYS
// Notes   : Output changes only when stages two and three agree
`timescale 1ns/1ps
module gpm_sync #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         clk,
    input  wire         srst,
    // Data
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] s1;  // First stage, read only by s2
    reg [W-1:0] s2;  // Second stage
    reg [W-1:0] s3;  // Third stage
    integer i;
    // =============================================
    // Stages and agreement filter
    always @(posedge clk) begin
        if (srst) begin
            s1 <= {W{1'b0}};
            s2 <= {W{1'b0}};
            s3 <= {W{1'b0}};
            q  <= {W{1'b0}};
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            // Only update bits where two and three agree
            for (i = 0; i < W; i = i + 1) begin
                if (s2[i] == s3[i]) begin
                    q[i] <= s3[i];
                end
            end
        end
    end
endmodule

// [gpm_top.v]
// Purpose : GPIO banks A-C, output-only and input-only banks, pin function select
// Assumes : Controller bus: 16-bit address, 8-bit data, one-cycle write and read strobes
// Notes   : Pins are split into input, output and output-enable signals
//           Pin reads pass a three-stage filter, so a pin change shows
//           in the input registers only three to four clocks later
//           Read data is captured on the read strobe and then holds
//           Alternate functions take their pins one cycle after the select write
// Notes on behaviour
// - Direction bit one drives, zero inputs; reset zero
// - Output bit drives pin when output; reset zero
// - Input register reads live pin level; here it reads the three-stage filtered level, three to four clocks late
// - Bank B holds pins eight to fifteen
// - Bank C pins 16-21; bits 6-7 zero
// - Function select bits reset zero, general purpose
// - Non keyboard function disconnects port, pulls high
// - Deselected keyboard port inputs seen high
// - Disabled keyboard channels receive high inputs
// - Infrared pins from block or data bits
// - Pins eight, nine become infrared UART
`timescale 1ns/1ps
`include "gpm_regs.vh"
module gpm_top (
    // Clock and reset
    input  wire        CLK_SYS,
    input  wire        SRST,
    // Controller register port
    input  wire [15:0] ADDR,
    input  wire        WR,
    input  wire        RD,
    input  wire [7:0]  WDATA,
    output reg  [7:0]  RDATA,
    // Bidirectional GPIO pins 0..21
    input  wire [21:0] GPIO_I,
    output reg  [21:0] GPIO_O,
    output reg  [21:0] GPIO_OE,
    // Output-only pins 0..11
    output reg  [11:0] OUT_PIN,
    // Input-only pins 0..7
    input  wire [7:0]  IN_PIN,
    // Interrupt sources routed to shared pins
    input  wire [4:0]  IRQ_SRC,
    input  wire        SYSTEM_MGMT_INTERRUPT_N,
    input  wire        SERIAL_IRQ_O,
    input  wire        SERIAL_IRQ_OE,
    input  wire        IRQ3_SRC,
    output reg         SERIAL_IRQ_LINE_O,
    output reg         SERIAL_IRQ_LINE_OE,
    output wire        SERIAL_IRQ_I,
    // Pulse modulators, floppy, address gate
    input  wire        PULSE_MOD_OUT_PIN_0,
    input  wire        PULSE_MOD_OUT1,
    input  wire        FLOPPY_DRIVE_SELECT1_N,
    input  wire        FLOPPY_MOTOR1_N,
    input  wire        ADDRESS_LINE20_GATE,
    // Keyboard port function (open drain on pins 20, 21)
    input  wire        KBD_PORT_CLOCK_OE,
    input  wire        KBD_PORT_DATA_OE,
    output wire        KBD_PORT_CLOCK_I,
    output wire        KBD_PORT_DATA_I,
    input  wire [3:0]  KBD_CHANNEL_EN,
    input  wire [3:0]  KBD_CHANNEL_CLK,
    input  wire [3:0]  KBD_CHANNEL_DAT,
    output wire [3:0]  KBD_CHANNEL_CLK_I,
    output wire [3:0]  KBD_CHANNEL_DAT_I,
    // Controller UART
    input  wire        CTRL_UART_TX,
    output wire        CTRL_UART_RX,
    // Infrared block and data register bits
    input  wire        IR_BLOCK_TX,
    output wire        IR_BLOCK_RX,
    input  wire        IR_DATA_TX,
    output wire        IR_DATA_RX,
    output reg         INFRARED_TX_PIN,
    input  wire        INFRARED_RX_PIN,
    input  wire        IR_UART_TX,
    output wire        IR_UART_RX,
    // Select bits for other logic
    output wire [7:0]  FSEL
);
    // =============================================
    // Decode helpers
    // Address compare used by every register write decode
    // Full 16-bit compare, so no register shows up at an alias
    function hit;
        input [15:0] a;
        input [15:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // =============================================
    // Stored state and filtered pin levels
    wire [7:0] dir_a;   // Bank A direction
    wire [7:0] out_a;   // Bank A output
    wire [7:0] dir_b;   // Bank B direction
    wire [7:0] out_b;   // Bank B output
    wire [5:0] dir_c;   // Bank C direction
    wire [5:0] out_c;   // Bank C output
    reg  [7:0] out_lo;  // Output-only bank low
    reg  [3:0] out_hi;  // Output-only bank high
    reg  [7:0] fsel;    // Pin function select
    wire [21:0] gpio_s; // Synchronised pins
    wire [7:0]  in_s;   // Synchronised input-only pins
    wire        infrared_rx_pin_s; // Synchronised infrared receive
    reg  [7:0]  next_rdata;
    wire [7:0]  rst_ohi = `GPM_RST_OHI;  // High output bank reset, cut to width below

    // Select bits are exported so neighbouring blocks follow the pin plan
    assign FSEL = fsel;

    // =============================================
    // Bidirectional banks
    // Each bank gets its two write strobes, decoded here from the address
    // bank B on pins 8-15
    gpm_bank #(.W(8)) u_bank_a (
        .clk     (CLK_SYS),
        .srst    (SRST),
        .wr_dir  (WR && hit(ADDR, `GPM_DIR_A)),
        .wr_out  (WR && hit(ADDR, `GPM_OUT_A)),
        .wdata   (WDATA),
        .dir     (dir_a),
        .out_val (out_a)
    );
    gpm_bank #(.W(8)) u_bank_b (
        .clk     (CLK_SYS),
        .srst    (SRST),
        .wr_dir  (WR && hit(ADDR, `GPM_DIR_B)),
        .wr_out  (WR && hit(ADDR, `GPM_OUT_B)),
        .wdata   (WDATA),
        .dir     (dir_b),
        .out_val (out_b)
    );
    gpm_bank #(.W(`GPM_C_BITS)) u_bank_c (
        .clk     (CLK_SYS),
        .srst    (SRST),
        .wr_dir  (WR && hit(ADDR, `GPM_DIR_C)),
        .wr_out  (WR && hit(ADDR, `GPM_OUT_C)),
        .wdata   (WDATA),
        .dir     (dir_c),
        .out_val (out_c)
    );

    // =============================================
    // Pin input synchronisers
    // One filter for every asynchronous input; the order of the
    // concatenation must match on the input and output sides
    gpm_sync #(.W(31)) u_sync (
        .clk  (CLK_SYS),
        .srst (SRST),
        .d    ({INFRARED_RX_PIN, IN_PIN, GPIO_I}),
        .q    ({infrared_rx_pin_s, in_s, gpio_s})
    );

    // =============================================
    // Output-only banks and function select
    // The output-only pins come up high, so loads on them see an
    // inactive level until firmware writes its first value
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            out_lo <= `GPM_RST_OLO;
            out_hi <= rst_ohi[`GPM_OHI_BITS-1:0];
            fsel   <= `GPM_RST_FSEL;
        end else if (WR) begin
            // Unmapped writes fall through and change nothing
            // output-only bank writes
            if (hit(ADDR, `GPM_OUTONLY_LO)) begin
                out_lo <= WDATA;
            end
            if (hit(ADDR, `GPM_OUTONLY_HI)) begin
                out_hi <= WDATA[`GPM_OHI_BITS-1:0];
            end
            // A new select takes effect on the pins in the next cycle
            // firmware selects functions
            if (hit(ADDR, `GPM_FSEL1)) begin
                fsel <= WDATA;
            end
        end
    end

    // =============================================
    // Read mux, registered; unmapped reads zero
    // Decode is combinational; only the captured byte is a flop,
    // which keeps RDATA steady between reads
    always @* begin
        next_rdata = 8'h00;
        case (ADDR)
            `GPM_DIR_A:      next_rdata = dir_a;
            `GPM_OUT_A:      next_rdata = out_a;
            `GPM_IN_A:       next_rdata = gpio_s[7:0];
            `GPM_DIR_B:      next_rdata = dir_b;
            `GPM_OUT_B:      next_rdata = out_b;
            `GPM_IN_B:       next_rdata = gpio_s[15:8];
            `GPM_DIR_C:      next_rdata = {2'b00, dir_c};
            `GPM_OUT_C:      next_rdata = {2'b00, out_c};
            `GPM_IN_C:       next_rdata = {2'b00, gpio_s[21:16]};
            `GPM_OUTONLY_LO: next_rdata = out_lo;
            `GPM_OUTONLY_HI: next_rdata = {4'h0, out_hi};
            `GPM_INONLY:     next_rdata = in_s;
            `GPM_FSEL1:      next_rdata = fsel;
            default:         next_rdata = 8'h00;
        endcase
    end

    // Capture the selected byte on the read strobe only
    // A write in the same cycle is not seen until the next read
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= next_rdata;
        end
    end

    // =============================================
    // Pin function decode
    // One wire per select bit; the keyboard port and transmit selects share pin 21
    wire irq_sel  = fsel[`GPM_IRQ_ROUTE];
    wire ps2_sel  = fsel[`GPM_PS2_SEL];
    wire ir_src   = fsel[`GPM_IR_SRC];
    wire utx_sel  = fsel[`GPM_UTX_SEL];
    wire pwm_sel  = fsel[`GPM_PWM_SEL];
    wire fdd_sel  = fsel[`GPM_FLOPPY_SEL];
    wire a20_sel  = fsel[`GPM_A20_SEL];
    wire iru_sel  = fsel[`GPM_IRUART_SEL];

    // Output-only pins with their alternate sources
    // Pins 8 and 9 keep their register bits in every mode
    always @* begin
        OUT_PIN = {out_hi, out_lo};
        if (irq_sel) begin
            OUT_PIN[4:0] = IRQ_SRC;
            OUT_PIN[7]   = SYSTEM_MGMT_INTERRUPT_N;
        end
        if (fdd_sel) begin
            OUT_PIN[5] = FLOPPY_DRIVE_SELECT1_N;
            OUT_PIN[6] = FLOPPY_MOTOR1_N;
        end
        if (pwm_sel) begin
            OUT_PIN[10] = PULSE_MOD_OUT_PIN_0;
            OUT_PIN[11] = PULSE_MOD_OUT1;
        end
    end

    // Serial IRQ pin or direct IRQ
    always @* begin
        if (irq_sel) begin
            SERIAL_IRQ_LINE_O  = IRQ3_SRC;
            SERIAL_IRQ_LINE_OE = 1'b1;
        end else begin
            SERIAL_IRQ_LINE_O  = SERIAL_IRQ_O;
            SERIAL_IRQ_LINE_OE = SERIAL_IRQ_OE;
        end
    end
    // Limitation: the serial IRQ pin has no input path here, so the
    // received level is tied to its inactive high
    assign SERIAL_IRQ_I = 1'b1;

    // Bidirectional pin drive
    // Alternate functions override the register view pin by pin;
    // the keyboard port wins over the transmit select on pin 21
    always @* begin
        GPIO_O  = {out_c, out_b, out_a};
        GPIO_OE = {dir_c, dir_b, dir_a};
        if (iru_sel) begin
            // Pin 8 released so the infrared receiver can listen
            GPIO_O[9]  = IR_UART_TX;
            GPIO_OE[9] = 1'b1;
            GPIO_OE[8] = 1'b0;
        end
        if (a20_sel) begin
            GPIO_O[17]  = ADDRESS_LINE20_GATE;
            GPIO_OE[17] = 1'b1;
        end
        if (ps2_sel) begin
            GPIO_O[20]  = 1'b0;
            GPIO_OE[20] = KBD_PORT_CLOCK_OE;
            GPIO_O[21]  = 1'b0;
            GPIO_OE[21] = KBD_PORT_DATA_OE;
        end else if (utx_sel) begin
            // Direction bit stays in charge; firmware must set it first
            // direction bit gates transmit
            GPIO_O[21]  = CTRL_UART_TX;
        end
    end

    // =============================================
    // Keyboard port inputs
    // A disconnected path reads high so the keyboard logic sees an
    // idle bus instead of whatever the pins happen to carry
    // disconnected path pulled high
    assign KBD_PORT_CLOCK_I = ps2_sel ? gpio_s[20] : 1'b1;
    assign KBD_PORT_DATA_I  = ps2_sel ? gpio_s[21] : 1'b1;

    // Channels share receive paths, so an idle one must never pull
    // a shared line low
    // disabled channels see high
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_chan
            assign KBD_CHANNEL_CLK_I[g] = KBD_CHANNEL_EN[g] ? KBD_CHANNEL_CLK[g] : 1'b1;
            assign KBD_CHANNEL_DAT_I[g] = KBD_CHANNEL_EN[g] ? KBD_CHANNEL_DAT[g] : 1'b1;
        end
    endgenerate

    assign CTRL_UART_RX = ps2_sel ? 1'b1 : gpio_s[20];

    assign IR_UART_RX = iru_sel ? gpio_s[8] : 1'b1;

    // =============================================
    // Infrared pin source
    // The unselected receiver reads idle high so it never sees
    // stray frames meant for the other source
    always @* begin
        INFRARED_TX_PIN = ir_src ? IR_DATA_TX : IR_BLOCK_TX;
    end
    assign IR_BLOCK_RX = ir_src ? 1'b1 : infrared_rx_pin_s;
    assign IR_DATA_RX  = ir_src ? infrared_rx_pin_s : 1'b1;
endmodule

// [test_gpio_banks_and_pin_mux.sv]
// Purpose: Self-checking bench for the GPIO and pin select block
// Assumes: Board model resolves the pads
// Notes: Pin reads wait out the input filter
`timescale 1ns/1ps
// ==========================
// Bench
module test_gpio_banks_and_pin_mux;
    logic        CLK_SYS, SRST, WR, RD, SERIAL_IRQ_I;
    logic [15:0] ADDR;
    logic [7:0]  WDATA, RDATA, IN_PIN, FSEL;
    logic [21:0] GPIO_I, GPIO_O, GPIO_OE;
    logic [23:0] ext;
    logic [11:0] OUT_PIN;
    logic [4:0]  IRQ_SRC;
    logic [3:0]  KBD_CHANNEL_EN, KBD_CHANNEL_CLK, KBD_CHANNEL_DAT, KBD_CHANNEL_CLK_I, KBD_CHANNEL_DAT_I;
    logic SYSTEM_MGMT_INTERRUPT_N, SERIAL_IRQ_O, SERIAL_IRQ_OE, IRQ3_SRC, SERIAL_IRQ_LINE_O, SERIAL_IRQ_LINE_OE;
    logic PULSE_MOD_OUT_PIN_0, PULSE_MOD_OUT1, FLOPPY_DRIVE_SELECT1_N, FLOPPY_MOTOR1_N, ADDRESS_LINE20_GATE;
    logic KBD_PORT_CLOCK_OE, KBD_PORT_DATA_OE, KBD_PORT_CLOCK_I, KBD_PORT_DATA_I, CTRL_UART_TX, CTRL_UART_RX;
    logic IR_BLOCK_TX, IR_BLOCK_RX, IR_DATA_TX, IR_DATA_RX, INFRARED_TX_PIN, INFRARED_RX_PIN, IR_UART_TX, IR_UART_RX;
    int          checked;
    int          num_errors;
    // Reset table: address then value
    logic [23:0] rst_tab [10] = '{24'h7f1800, 24'h7f1900, 24'h7f1b00, 24'h7f1c00, 24'h7f1e00,
                                  24'h7f1f00, 24'h7f22ff, 24'h7f230f, 24'h7f3d00, 24'h7f2100};
    gpm_top gpm_top_inst (.*);
    gpm_board gpm_board_inst (.pad_o(GPIO_O), .pad_oe(GPIO_OE), .ext(ext[21:0]), .pad_i(GPIO_I));
    // ==========================
    // Clock
    initial begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end
    // ==========================
    // Shared steps
    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        #1;
    endtask
    // Read data lands one edge after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge CLK_SYS);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        #1 chk({14'h0, RDATA}, {14'h0, e});
    endtask
    // ==========================
    // Scenarios
    task automatic t_reset;
        #1 chk(GPIO_OE, 22'h0);
        chk({10'h0, OUT_PIN}, 22'hfff);
        for (int i = 0; i < 10; i++) begin
            rd(rst_tab[i][23:8], rst_tab[i][7:0]);
        end
    endtask
    // Drive, read back, then release to board levels
    task automatic t_banks;
        logic [7:0]  m;
        logic [15:0] a;
        for (int b = 0; b < 3; b++) begin
            m = (b == 2) ? 8'h3f : 8'hff;
            a = 16'(16'h7f18 + 3 * b);
            wr(a, 8'hff);
            wr(a + 16'h1, 8'h5a);
            rd(a, m);
            rd(a + 16'h1, 8'h5a & m);
            cyc(5);
            rd(a + 16'h2, 8'h5a & m);
            wr(a, 8'h00);
            cyc(5);
            rd(a + 16'h2, ext[8*b +: 8] & m);
        end
    endtask
    task automatic t_outs;
        wr(16'h7f22, 8'h3c);
        wr(16'h7f23, 8'hf5);
        @(posedge CLK_SYS) IN_PIN <= 8'h96;
        rd(16'h7f23, 8'h05);
        chk({10'h0, OUT_PIN}, 22'h53c);
        cyc(5);
        rd(16'h7f24, 8'h96);
    endtask
    // Alternate sources replace register bits
    task automatic t_alt;
        chk({19'h0, SERIAL_IRQ_I, SERIAL_IRQ_LINE_O, SERIAL_IRQ_LINE_OE}, 22'h7);
        @(posedge CLK_SYS);
        SERIAL_IRQ_OE           <= 1'b0;
        IRQ_SRC                 <= 5'h15;
        SYSTEM_MGMT_INTERRUPT_N <= 1'b0;
        PULSE_MOD_OUT_PIN_0          <= 1'b1;
        FLOPPY_MOTOR1_N         <= 1'b1;
        ADDRESS_LINE20_GATE     <= 1'b1;
        wr(16'h7f3d, 8'h71);
        chk({10'h0, OUT_PIN}, 22'h555);
        chk({18'h0, GPIO_OE[17], GPIO_O[17], SERIAL_IRQ_LINE_O, SERIAL_IRQ_LINE_OE}, 22'hd);
        rd(16'h7f3d, 8'h71);
    endtask
    task automatic t_ps2;
        wr(16'h7f3d, 8'h02);
        cyc(5);
        chk({21'h0, KBD_PORT_DATA_I}, 22'h1);
        @(posedge CLK_SYS) {KBD_PORT_CLOCK_OE, KBD_PORT_DATA_OE} <= 2'b11;
        #1 chk({18'h0, GPIO_OE[21:20], GPIO_O[21:20]}, 22'hc);
        cyc(5);
        chk({20'h0, KBD_PORT_CLOCK_I, KBD_PORT_DATA_I}, 22'h0);
        wr(16'h7f3d, 8'h00);
        cyc(5);
        chk({20'h0, KBD_PORT_CLOCK_I, CTRL_UART_RX}, 22'h2);
        wr(16'h7f1e, 8'h20);
        wr(16'h7f3d, 8'h08);
        chk({20'h0, GPIO_OE[21], GPIO_O[21]}, 22'h2);
        @(posedge CLK_SYS);
        {KBD_PORT_CLOCK_OE, KBD_PORT_DATA_OE} <= 2'b00;
        KBD_CHANNEL_EN   <= 4'h5;
        #1 chk({14'h0, KBD_CHANNEL_CLK_I, KBD_CHANNEL_DAT_I}, 22'haa);
    endtask
    task automatic t_ir;
        @(posedge CLK_SYS) IR_BLOCK_TX <= 1'b1;
        cyc(5);
        chk({18'h0, INFRARED_TX_PIN, IR_BLOCK_RX, IR_DATA_RX, IR_UART_RX}, 22'hb);
        // Pin 8 driven first, so the forced release under the UART select shows
        wr(16'h7f1b, 8'h01);
        wr(16'h7f3d, 8'h84);
        cyc(5);
        chk({19'h0, INFRARED_TX_PIN, IR_BLOCK_RX, IR_DATA_RX}, 22'h2);
        chk({18'h0, GPIO_OE[9:8], GPIO_O[9], IR_UART_RX}, 22'h8);
        wr(16'h7f3d, 8'h00);
    endtask
    // ==========================
    // Verdict
    task automatic summarize;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog well past the expected run
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
    // Main sequence, with a second reset after the scenarios
    initial begin
        {WR, RD, ADDR, WDATA, IN_PIN, IRQ_SRC, IRQ3_SRC, PULSE_MOD_OUT_PIN_0, PULSE_MOD_OUT1, KBD_CHANNEL_EN} = '0;
        {KBD_CHANNEL_CLK, KBD_CHANNEL_DAT, KBD_PORT_CLOCK_OE, KBD_PORT_DATA_OE, CTRL_UART_TX} = '0;
        {FLOPPY_DRIVE_SELECT1_N, FLOPPY_MOTOR1_N, ADDRESS_LINE20_GATE, IR_BLOCK_TX, IR_DATA_TX} = '0;
        {INFRARED_RX_PIN, IR_UART_TX} = '0;
        {SYSTEM_MGMT_INTERRUPT_N, SERIAL_IRQ_O, SERIAL_IRQ_OE, SRST} = 4'hf;
        ext = 24'h25a2c6;
        checked = 0;
        num_errors = 0;
        repeat (2) @(posedge CLK_SYS);
        SRST <= 1'b0;
        t_reset();
        t_banks();
        t_outs();
        t_alt();
        t_ps2();
        t_ir();
        @(posedge CLK_SYS) SRST <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        SRST <= 1'b0;
        t_reset();
        summarize();
    end
endmodule
